// file: design/board_io_cfg.svh
// Offsets, field positions, reset values and counts for the board configuration block.
// Assumes a 4-bit word address register port and a 16-bit data path.
`ifndef BOARD_IO_CFG_SVH
`define BOARD_IO_CFG_SVH

`define ADDR_W          4
`define DATA_W          16
`define DIO_W           4

`define OFS_AO_CFG      4'h0
`define OFS_DIO_DIR     4'h1
`define OFS_DIO_DATA    4'h2
`define OFS_CLK_CFG     4'h3
`define OFS_AO0_WORD    4'h4
`define OFS_AO1_WORD    4'h5
`define OFS_STATUS      4'h6

`define AO_CFG_REF0     0
`define AO_CFG_BIP0     1
`define AO_CFG_REF1     2
`define AO_CFG_BIP1     3
`define CLK_CFG_SEL     0
`define CLK_CFG_DRIVE   1

`define RST_AO_CFG      4'h0
`define RST_DIO_DIR     2'h0
`define RST_DIO_DATA    8'h00
`define RST_CLK_DRIVE   1'b0
`define RST_AO_WORD     16'h0000

`define BIPOLAR_FLIP    16'h8000
`define TB_DIVIDE       10
`define TB_HALF         4'h5

`endif

// file: design/board_io_pkg.sv
// Types shared by the board configuration block and its sub-modules.
// Assumes the constants header is on the include path.
`include "board_io_cfg.svh"

package board_io_pkg;

  typedef enum logic {
    TB_INTERNAL,
    TB_BUS
  } tb_src_t;

  typedef struct packed {
    logic [3:0]  ao_cfg;
    logic [1:0]  dio_dir;
    logic [7:0]  dio_data;
    tb_src_t     clk_src;
    logic        clk_drive;
    logic [15:0] ao0_word;
    logic [15:0] ao1_word;
    logic [15:0] ao0_code;
    logic [15:0] ao1_code;
    logic [1:0]  ao_update;
    logic [15:0] rdata;
    logic        int_osc_q;
    logic        bus_clk_q;
    logic        tb_sample;
    logic        bus_drv;
    logic        bus_oe;
  } top_state_t;

  typedef struct packed {
    logic [3:0] pins;
    logic [3:0] oe;
    logic [3:0] rd;
  } dio_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       prev;
    logic       out;
  } div_state_t;

endpackage : board_io_pkg

// file: design/dio_port4.sv
// One 4-bit digital port whose direction applies to all four lines together.
// Assumes pin levels are synchronous to the system clock.
`timescale 1ns/100ps
`include "board_io_cfg.svh"

module dio_port4 (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       dir_out_in,
  input  wire logic [3:0] data_in,
  input  wire logic [3:0] pins_in,
  output logic      [3:0] pins_out,
  output logic      [3:0] pins_oe_out,
  output logic      [3:0] rd_out
);
  import board_io_pkg::*;

  dio_state_t st_ff;
  dio_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.pins = data_in;
    nxt_st.oe   = {4{dir_out_in}}; // RULE6
    nxt_st.rd   = dir_out_in ? data_in : pins_in;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0; // RULE7
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins_out    = st_ff.pins;
  assign pins_oe_out = st_ff.oe;
  assign rd_out      = st_ff.rd;

  a_port_whole_dir: assert property ( // RULE6
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |=> (pins_oe_out == {4{$past(dir_out_in)}}))
    else $error("Port direction does not follow its setting.");

endmodule : dio_port4

// file: design/timebase_divider.sv
// Divides a sampled timebase by ten, counting its rising edges.
// Assumes the timebase sample is a level taken on the system clock.
`timescale 1ns/100ps
`include "board_io_cfg.svh"

module timebase_divider (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic tb_in,
  output logic      div_out
);
  import board_io_pkg::*;

  div_state_t st_ff;
  div_state_t nxt_st;
  logic       rise;

  assign rise = tb_in && !st_ff.prev;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.prev = tb_in;
    if (rise) begin
      if (st_ff.cnt == `TB_HALF - 4'h1) begin
        nxt_st.cnt = 4'h0;
        nxt_st.out = !st_ff.out; // RULE10
      end else begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign div_out = st_ff.out;

  a_div_toggle_cause: assert property ( // RULE10
    @(posedge sys_clk_in) disable iff (rst_in)
    $changed(div_out) |-> ($past(rise) && ($past(st_ff.cnt) == `TB_HALF - 4'h1)))
    else $error("Divided timebase toggled without its fifth input edge.");

endmodule : timebase_divider

// file: design/board_output_dio_clock_config.sv
// Configuration logic for output converters, digital port direction and board timebase.
// Assumes a register port with one-cycle strobes and read data one cycle later,
// and pin and oscillator levels synchronous to sys_clk_in.
//
// Notes on behaviour
// (RULE1) Each output channel selects internal 10 V or external reference, independently.
// (RULE2) Each output channel has its own unipolar or bipolar polarity setting.
// (RULE3) Bipolar channel words are two's complement, 8000 to 7FFF hex.
// (RULE4) Unipolar channel words are straight binary, 0 to FFFF hex.
// (RULE5) Eight digital lines form two ports of four bits.
// (RULE6) Each digital port has one direction setting for the whole port.
// (RULE7) Reset puts both digital ports in input direction.
// (RULE8) Timebase select picks internal oscillator or timing bus clock.
// (RULE9) Bus clock is driven only when drive is on and internal selected.
// (RULE10) Selected timebase divided by ten feeds the counter/timer.
// (RULE11) After startup internal timebase is used and bus clock is undriven.
// (RULE12) Only one board on the timing bus drives its clock.
// (RULE13) Settings live in host bits, act next clock, default on reset; port direction and bus drive reach their outputs two clocks after the write.
`timescale 1ns/100ps
`include "board_io_cfg.svh"

module board_output_dio_clock_config (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic [`ADDR_W-1:0]  reg_addr_in,
  input  wire logic [`DATA_W-1:0]  reg_wdata_in,
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  output logic      [`DATA_W-1:0]  reg_rdata_out,
  output logic      [1:0]          ao_ref_ext_out,
  output logic      [1:0]          ao_bipolar_out,
  output logic      [`DATA_W-1:0]  ao0_code_out,
  output logic      [`DATA_W-1:0]  ao1_code_out,
  output logic      [1:0]          ao_update_out,
  input  wire logic [`DIO_W-1:0]   digital_port_a_lines_in,
  output logic      [`DIO_W-1:0]   digital_port_a_lines_out,
  output logic      [`DIO_W-1:0]   digital_port_a_lines_oe_out,
  input  wire logic [`DIO_W-1:0]   digital_port_b_lines_in,
  output logic      [`DIO_W-1:0]   digital_port_b_lines_out,
  output logic      [`DIO_W-1:0]   digital_port_b_lines_oe_out,
  input  wire logic                int_osc_in,
  input  wire logic                bus_clk_in,
  output logic                     bus_clk_out,
  output logic                     bus_clk_oe_out,
  output logic                     counter_source_out
);
  import board_io_pkg::*;

  // True when the register port addresses the given word.
  function automatic logic addr_hit(input logic [`ADDR_W-1:0] addr,
                                    input logic [`ADDR_W-1:0] ofs);
    return addr == ofs;
  endfunction : addr_hit

  // Converter code from a host word: bipolar words are two's complement and
  // are flipped to offset binary; unipolar words pass as straight binary.
  function automatic logic [`DATA_W-1:0] to_code(input logic [`DATA_W-1:0] word,
                                                 input logic               bipolar);
    return bipolar ? (word ^ `BIPOLAR_FLIP) : word;
  endfunction : to_code

  top_state_t               st_ff;
  top_state_t               nxt_st;
  logic       [1:0][3:0]    dio_in;
  logic       [1:0][3:0]    dio_pins;
  logic       [1:0][3:0]    dio_oe;
  logic       [1:0][3:0]    dio_rd;
  logic                     div_q;
  logic                     wr_ao_cfg;
  logic                     wr_dio_dir;
  logic                     wr_dio_data;
  logic                     wr_clk_cfg;
  logic                     wr_ao0;
  logic                     wr_ao1;

  assign wr_ao_cfg   = reg_wr_in && addr_hit(reg_addr_in, `OFS_AO_CFG);
  assign wr_dio_dir  = reg_wr_in && addr_hit(reg_addr_in, `OFS_DIO_DIR);
  assign wr_dio_data = reg_wr_in && addr_hit(reg_addr_in, `OFS_DIO_DATA);
  assign wr_clk_cfg  = reg_wr_in && addr_hit(reg_addr_in, `OFS_CLK_CFG);
  assign wr_ao0      = reg_wr_in && addr_hit(reg_addr_in, `OFS_AO0_WORD);
  assign wr_ao1      = reg_wr_in && addr_hit(reg_addr_in, `OFS_AO1_WORD);

  assign dio_in[0] = digital_port_a_lines_in;
  assign dio_in[1] = digital_port_b_lines_in;

  // Two identical 4-bit ports, each with its own direction bit.
  for (genvar p = 0; p < 2; p++) begin : g_port // RULE5
    dio_port4 u_port (
      .sys_clk_in  (sys_clk_in),
      .rst_in      (rst_in),
      .dir_out_in  (st_ff.dio_dir[p]),
      .data_in     (st_ff.dio_data[p*4 +: 4]),
      .pins_in     (dio_in[p]),
      .pins_out    (dio_pins[p]),
      .pins_oe_out (dio_oe[p]),
      .rd_out      (dio_rd[p])
    );
  end

  timebase_divider u_div (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .tb_in      (st_ff.tb_sample),
    .div_out    (div_q)
  );

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.ao_update = 2'b00;

    if (wr_ao_cfg) begin
      nxt_st.ao_cfg = reg_wdata_in[3:0]; // RULE1 RULE2 RULE13
    end
    if (wr_dio_dir) begin
      nxt_st.dio_dir = reg_wdata_in[1:0]; // RULE6 RULE13
    end
    if (wr_dio_data) begin
      nxt_st.dio_data = reg_wdata_in[7:0];
    end
    if (wr_clk_cfg) begin
      nxt_st.clk_src   = reg_wdata_in[`CLK_CFG_SEL] ? TB_BUS : TB_INTERNAL; // RULE8
      nxt_st.clk_drive = reg_wdata_in[`CLK_CFG_DRIVE];
    end
    if (wr_ao0) begin
      nxt_st.ao0_word     = reg_wdata_in;
      nxt_st.ao_update[0] = 1'b1;
    end
    if (wr_ao1) begin
      nxt_st.ao1_word     = reg_wdata_in;
      nxt_st.ao_update[1] = 1'b1;
    end

    // Codes track both the stored word and the polarity, so a polarity change
    // alone re-encodes the word already held.
    nxt_st.ao0_code = to_code(st_ff.ao0_word, st_ff.ao_cfg[`AO_CFG_BIP0]); // RULE3 RULE4
    nxt_st.ao1_code = to_code(st_ff.ao1_word, st_ff.ao_cfg[`AO_CFG_BIP1]); // RULE3 RULE4

    nxt_st.int_osc_q = int_osc_in;
    nxt_st.bus_clk_q = bus_clk_in;
    nxt_st.tb_sample = (st_ff.clk_src == TB_BUS) ? st_ff.bus_clk_q : st_ff.int_osc_q; // RULE8

    // The bus is only driven from the internal oscillator, never looped back
    // from a received bus clock; the host keeps one driver per bus.
    nxt_st.bus_drv = st_ff.int_osc_q;
    nxt_st.bus_oe  = st_ff.clk_drive && (st_ff.clk_src == TB_INTERNAL); // RULE9 RULE12

    nxt_st.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        `OFS_AO_CFG:   nxt_st.rdata = {12'h000, st_ff.ao_cfg};
        `OFS_DIO_DIR:  nxt_st.rdata = {14'h0000, st_ff.dio_dir};
        `OFS_DIO_DATA: nxt_st.rdata = {8'h00, dio_rd[1], dio_rd[0]};
        `OFS_CLK_CFG:  nxt_st.rdata = {14'h0000, st_ff.clk_drive, st_ff.clk_src};
        `OFS_AO0_WORD: nxt_st.rdata = st_ff.ao0_word;
        `OFS_AO1_WORD: nxt_st.rdata = st_ff.ao1_word;
        `OFS_STATUS:   nxt_st.rdata = {13'h0000, div_q, st_ff.bus_oe, st_ff.clk_src};
        default:       nxt_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff           <= '0;
      st_ff.ao_cfg    <= `RST_AO_CFG; // RULE13
      st_ff.dio_dir   <= `RST_DIO_DIR; // RULE7
      st_ff.dio_data  <= `RST_DIO_DATA;
      st_ff.clk_src   <= TB_INTERNAL; // RULE11
      st_ff.clk_drive <= `RST_CLK_DRIVE; // RULE11
      st_ff.ao0_word  <= `RST_AO_WORD;
      st_ff.ao1_word  <= `RST_AO_WORD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_out               = st_ff.rdata;
  assign ao_ref_ext_out              = {st_ff.ao_cfg[`AO_CFG_REF1], st_ff.ao_cfg[`AO_CFG_REF0]};
  assign ao_bipolar_out              = {st_ff.ao_cfg[`AO_CFG_BIP1], st_ff.ao_cfg[`AO_CFG_BIP0]};
  assign ao0_code_out                = st_ff.ao0_code;
  assign ao1_code_out                = st_ff.ao1_code;
  assign ao_update_out               = st_ff.ao_update;
  assign digital_port_a_lines_out    = dio_pins[0];
  assign digital_port_a_lines_oe_out = dio_oe[0];
  assign digital_port_b_lines_out    = dio_pins[1];
  assign digital_port_b_lines_oe_out = dio_oe[1];
  assign bus_clk_out                 = st_ff.bus_drv;
  assign bus_clk_oe_out              = st_ff.bus_oe;
  assign counter_source_out          = div_q;

  sequence s_cfg_write;
    reg_wr_in && addr_hit(reg_addr_in, `OFS_AO_CFG);
  endsequence

  sequence s_clk_write;
    reg_wr_in && addr_hit(reg_addr_in, `OFS_CLK_CFG);
  endsequence

  sequence s_dir_write;
    reg_wr_in && addr_hit(reg_addr_in, `OFS_DIO_DIR);
  endsequence

  sequence s_ao0_write;
    reg_wr_in && addr_hit(reg_addr_in, `OFS_AO0_WORD);
  endsequence

  sequence s_ao1_write;
    reg_wr_in && addr_hit(reg_addr_in, `OFS_AO1_WORD);
  endsequence

  a_ref_select: assert property ( // RULE1
    @(posedge sys_clk_in) disable iff (rst_in)
    s_cfg_write |=> (ao_ref_ext_out == {$past(reg_wdata_in[2]), $past(reg_wdata_in[0])}))
    else $error("Reference select did not follow the write.");

  a_polarity_select: assert property ( // RULE2
    @(posedge sys_clk_in) disable iff (rst_in)
    s_cfg_write |=> (ao_bipolar_out == {$past(reg_wdata_in[3]), $past(reg_wdata_in[1])}))
    else $error("Polarity select did not follow the write.");

  a_bipolar_code: assert property ( // RULE3
    @(posedge sys_clk_in) disable iff (rst_in)
    (st_ff.ao_cfg[`AO_CFG_BIP0] && st_ff.ao0_word == 16'h8000) |=> (ao0_code_out == 16'h0000))
    else $error("Most negative bipolar word did not map to code zero.");

  a_unipolar_code: assert property ( // RULE4
    @(posedge sys_clk_in) disable iff (rst_in)
    !st_ff.ao_cfg[`AO_CFG_BIP1] |=> (ao1_code_out == $past(st_ff.ao1_word)))
    else $error("Unipolar word was not passed as straight binary.");

  a_dio_input_dir: assert property ( // RULE7
    @(posedge sys_clk_in) disable iff (rst_in)
    (st_ff.dio_dir == 2'b00) |=> (digital_port_a_lines_oe_out == 4'h0
                                  && digital_port_b_lines_oe_out == 4'h0))
    else $error("A digital port drives while set to input.");

  a_bus_drive_gate: assert property ( // RULE9
    @(posedge sys_clk_in) disable iff (rst_in)
    bus_clk_oe_out |-> ($past(st_ff.clk_drive) && $past(st_ff.clk_src) == TB_INTERNAL))
    else $error("Bus clock driven without drive on and internal source.");

  a_bus_drive_on: assert property ( // RULE9 RULE11
    @(posedge sys_clk_in) disable iff (rst_in)
    (s_clk_write and (reg_wdata_in[1:0] == 2'b10)) |=> ##1 bus_clk_oe_out)
    else $error("Bus clock not driven two cycles after enabling it.");

  a_timebase_select: assert property ( // RULE8
    @(posedge sys_clk_in) disable iff (rst_in)
    (st_ff.clk_src == TB_BUS) |=> (st_ff.tb_sample == $past(st_ff.bus_clk_q)))
    else $error("Selected timebase is not the bus clock.");

  a_read_latency: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    (reg_rd_in && addr_hit(reg_addr_in, `OFS_DIO_DIR))
      |=> (reg_rdata_out == {14'h0000, $past(st_ff.dio_dir)}))
    else $error("Direction readback wrong one cycle after the read.");

  a_dir_setting: assert property ( // RULE6 RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    s_dir_write |=> (st_ff.dio_dir == $past(reg_wdata_in[1:0])))
    else $error("Port direction setting did not follow the write.");

  a_ao0_update: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    s_ao0_write |=> (ao_update_out == 2'b01))
    else $error("Channel 0 update pulse missing after its word write.");

  a_ao1_update: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    s_ao1_write |=> (ao_update_out == 2'b10))
    else $error("Channel 1 update pulse missing after its word write.");

  a_bipolar_flip0: assert property ( // RULE3
    @(posedge sys_clk_in) disable iff (rst_in)
    st_ff.ao_cfg[`AO_CFG_BIP0] |=> (ao0_code_out == ($past(st_ff.ao0_word) ^ 16'h8000)))
    else $error("Bipolar channel 0 word was not taken as two's complement.");

  a_bipolar_flip1: assert property ( // RULE3
    @(posedge sys_clk_in) disable iff (rst_in)
    st_ff.ao_cfg[`AO_CFG_BIP1] |=> (ao1_code_out == ($past(st_ff.ao1_word) ^ 16'h8000)))
    else $error("Bipolar channel 1 word was not taken as two's complement.");

  a_unipolar_code0: assert property ( // RULE4
    @(posedge sys_clk_in) disable iff (rst_in)
    !st_ff.ao_cfg[`AO_CFG_BIP0] |=> (ao0_code_out == $past(st_ff.ao0_word)))
    else $error("Unipolar channel 0 word was not passed as straight binary.");

  a_word_hold0: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    !wr_ao0 |=> $stable(st_ff.ao0_word))
    else $error("Channel 0 word changed without a host write.");

  a_word_hold1: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    !wr_ao1 |=> $stable(st_ff.ao1_word))
    else $error("Channel 1 word changed without a host write.");

  a_bus_from_osc: assert property ( // RULE9
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |=> (bus_clk_out == $past(st_ff.int_osc_q)))
    else $error("Bus clock output is not the internal oscillator.");

  a_bus_off_received: assert property ( // RULE9
    @(posedge sys_clk_in) disable iff (rst_in)
    (st_ff.clk_src == TB_BUS) |=> !bus_clk_oe_out)
    else $error("Bus clock driven while the bus timebase is selected.");

  a_internal_select: assert property ( // RULE8 RULE11
    @(posedge sys_clk_in) disable iff (rst_in)
    (st_ff.clk_src == TB_INTERNAL) |=> (st_ff.tb_sample == $past(st_ff.int_osc_q)))
    else $error("Selected timebase is not the internal oscillator.");

  a_read_idle: assert property ( // RULE13
    @(posedge sys_clk_in) disable iff (rst_in)
    !reg_rd_in |=> (reg_rdata_out == 16'h0000))
    else $error("Read data not zero outside the cycle after a read.");

endmodule : board_output_dio_clock_config

// file: dv/host_bus_model.sv
// Host model: issues register cycles and acts as a peer board on the timing bus.
// Assumes one-cycle strobes, and read data that stands only in the cycle after the strobe.
`timescale 1ns/100ps

module host_bus_model (
  input  wire logic        sys_clk_in,
  input  wire logic [15:0] reg_rdata_in,
  input  wire logic        bus_clk_oe_in,
  output logic      [3:0]  reg_addr_out,
  output logic      [15:0] reg_wdata_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic             peer_clk_out,
  output logic             peer_oe_out
);
  logic [1:0] peer_div_ff = 2'h0;

  initial begin
    reg_addr_out  = 4'h0;
    reg_wdata_out = 16'h0000;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    peer_clk_out  = 1'b0;
  end

  // The peer releases the shared clock line whenever this board drives it.
  assign peer_oe_out = !bus_clk_oe_in;

  always @(posedge sys_clk_in) begin
    peer_div_ff <= peer_div_ff + 2'h1;
    if (peer_div_ff == 2'h3) begin
      peer_clk_out <= !peer_clk_out;
    end
  end

  task automatic write_reg(input logic [3:0] addr, input logic [15:0] data);
    @(posedge sys_clk_in);
    reg_addr_out  <= addr;
    reg_wdata_out <= data;
    reg_wr_out    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out    <= 1'b0;
  endtask : write_reg

  task automatic read_reg(input logic [3:0] addr, output logic [15:0] data);
    @(posedge sys_clk_in);
    reg_addr_out <= addr;
    reg_rd_out   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out   <= 1'b0;
    #1;
    data = reg_rdata_in;
  endtask : read_reg
endmodule : host_bus_model

// file: dv/tb_top.sv
// Self-checking bench for the board configuration block.
// Assumes the host model drives the register port and a peer board shares the timing bus.
`timescale 1ns/100ps
`include "board_io_cfg.svh"

module tb_top;
  logic        sys_clk_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        int_osc    = 1'b0;
  logic [3:0]  reg_addr, a_out, a_oe, b_out, b_oe, a_line, b_line;
  logic [3:0]  a_pins     = 4'hC;
  logic [3:0]  b_pins     = 4'h3;
  logic [15:0] reg_wdata, reg_rdata, ao0_code, ao1_code, rd;
  logic [1:0]  ref_ext, bipolar, update;
  logic        reg_wr, reg_rd, bus_drv, bus_oe, peer_clk, peer_oe, cnt_src, bus_line;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          cycles      = 0;

  assign a_line   = a_oe[0] ? a_out : a_pins;
  assign b_line   = b_oe[0] ? b_out : b_pins;
  assign bus_line = bus_oe ? bus_drv : (peer_oe ? peer_clk : 1'b0);

  board_output_dio_clock_config uut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata), .ao_ref_ext_out(ref_ext), .ao_bipolar_out(bipolar),
    .ao0_code_out(ao0_code), .ao1_code_out(ao1_code), .ao_update_out(update),
    .digital_port_a_lines_in(a_line), .digital_port_a_lines_out(a_out),
    .digital_port_a_lines_oe_out(a_oe), .digital_port_b_lines_in(b_line),
    .digital_port_b_lines_out(b_out), .digital_port_b_lines_oe_out(b_oe),
    .int_osc_in(int_osc), .bus_clk_in(bus_line), .bus_clk_out(bus_drv),
    .bus_clk_oe_out(bus_oe), .counter_source_out(cnt_src));

  host_bus_model host (
    .sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata), .bus_clk_oe_in(bus_oe),
    .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_wr_out(reg_wr),
    .reg_rd_out(reg_rd), .peer_clk_out(peer_clk), .peer_oe_out(peer_oe));

  always #4 sys_clk_in = !sys_clk_in;

  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles % 6 == 5) begin
      int_osc <= !int_osc;
    end
    if (cycles == 30000) begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Counts source rises between counter rises, skipping the first interval after a switch.
  task automatic measure(input logic use_bus);
    int   n;
    int   ph;
    logic s, sp, c, cp;
    n  = 0;
    ph = 0;
    sp = 1'b1;
    cp = 1'b1;
    for (int t = 0; t < 800 && ph < 3; t++) begin
      @(negedge sys_clk_in);
      s = use_bus ? bus_line : int_osc;
      c = cnt_src;
      if (ph == 2 && s && !sp) n++;
      if (c && !cp) ph++;
      sp = s;
      cp = c;
    end
    check(16'(n), 16'h000A);
  endtask : measure

  task automatic test_reset;
    host.read_reg(`OFS_STATUS, rd);
    check(16'({a_oe, b_oe}), 16'h0000);
    check(16'({bus_oe, ref_ext, bipolar}), 16'h0000);
    check(rd & 16'h0003, 16'h0000);
  endtask : test_reset

  task automatic test_ao_cfg;
    for (int i = 0; i < 16; i++) begin
      host.write_reg(`OFS_AO_CFG, 16'(i));
      #1;
      check(16'({ref_ext, bipolar}), 16'({i[2], i[0], i[3], i[1]}));
    end
  endtask : test_ao_cfg

  task automatic test_codes;
    logic [15:0] w[4];
    w = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFFF};
    host.write_reg(`OFS_AO_CFG, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      host.write_reg(`OFS_AO0_WORD, w[k]);
      #1;
      check(16'(update), 16'h0001);
      host.write_reg(`OFS_AO1_WORD, w[k]);
      #1;
      check(16'(update), 16'h0002);
      @(posedge sys_clk_in);
      #1;
      check(ao0_code, w[k] ^ 16'h8000);
      check(ao1_code, w[k]);
    end
    host.write_reg(`OFS_AO_CFG, 16'h0008);
    @(posedge sys_clk_in);
    #1;
    check(ao0_code, 16'hFFFF);
    check(ao1_code, 16'h7FFF);
  endtask : test_codes

  task automatic test_dio;
    host.write_reg(`OFS_DIO_DIR, 16'h0001);
    host.write_reg(`OFS_DIO_DATA, 16'h00A5);
    @(posedge sys_clk_in);
    #1;
    check(16'({a_oe, b_oe, a_out}), 16'h0F05);
    host.read_reg(`OFS_DIO_DATA, rd);
    check(rd, 16'h0035);
    host.write_reg(`OFS_DIO_DIR, 16'h0002);
    @(posedge sys_clk_in);
    #1;
    check(16'({a_oe, b_oe, b_out}), 16'h00FA);
    host.read_reg(`OFS_DIO_DATA, rd);
    check(rd, 16'h00AC);
    host.write_reg(`OFS_DIO_DIR, 16'h0003);
    @(posedge sys_clk_in);
    rst_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    check(16'({a_oe, b_oe, bus_oe, ref_ext, bipolar}), 16'h0000);
    @(posedge sys_clk_in);
    rst_in <= 1'b0;
  endtask : test_dio

  task automatic test_clock;
    measure(1'b0);
    host.write_reg(`OFS_CLK_CFG, 16'h0002);
    @(posedge sys_clk_in);
    #1;
    check(16'(bus_oe), 16'h0001);
    measure(1'b1);
    host.write_reg(`OFS_CLK_CFG, 16'h0003);
    @(posedge sys_clk_in);
    #1;
    check(16'(bus_oe), 16'h0000);
    host.read_reg(`OFS_STATUS, rd);
    check(rd & 16'h0003, 16'h0001);
    measure(1'b1);
    host.write_reg(`OFS_STATUS, 16'hFFFF);
    host.write_reg(4'h7, 16'hFFFF);
    host.read_reg(4'h7, rd);
    check(rd, 16'h0000);
    host.read_reg(`OFS_STATUS, rd);
    check(rd & 16'h0003, 16'h0001);
    check(16'({ref_ext, bipolar}), 16'h0000);
    host.write_reg(`OFS_CLK_CFG, 16'h0000);
    host.read_reg(`OFS_STATUS, rd);
    check(rd & 16'h0003, 16'h0000);
  endtask : test_clock

  task automatic finish_test;
    $display("Comparisons: %0d, mismatches: %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    test_reset();
    test_ao_cfg();
    test_codes();
    test_dio();
    test_clock();
    finish_test();
  end
endmodule : tb_top
